//--- verilog/lpr_dev.sv
// lpr_dev: sdram end of one channel; decodes two-edge commands, tracks
// bank refresh busy, self refresh, power down in self refresh and misuse.
// assumes the controller end drives lpr_if on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "lpr_map.svh"
module lpr_dev
  import lpr_pkg::*;
#(
  parameter int NUM_BANKS = `LPR_NUM_BANKS,
  parameter int REFI_CYC  = `LPR_REFI_CYC
)(
  input  wire logic                 mclk_i,
  input  wire logic                 rstn_i,
  lpr_if.dev                        link,
  output logic                      sr_active_o,
  output logic                      pd_active_o,
  output logic                      int_ref_o,
  output logic [NUM_BANKS-1:0]      bank_busy_o,
  output logic                      ref_owed_o,
  output logic                      cmd_err_o
);

  ////////////////////////////////////////////////////////////////////////////
  lpr_dev_st_e          st, next_st;
  logic                 half, next_half;
  logic [5:0]           op, next_op;
  logic [2:0]           ab_cnt, next_ab_cnt;
  logic [1:0]           pb_cnt [NUM_BANKS];
  logic [1:0]           next_pb_cnt [NUM_BANKS];
  logic [2:0]           ptr, next_ptr;
  logic [2:0]           opb, next_opb;
  logic                 any_busy;
  logic [2:0]           tmr, next_tmr;
  logic [9:0]           refi, next_refi;
  logic                 owed, next_owed;
  logic                 err, next_err;
  logic                 iref, next_iref;
  logic [NUM_BANKS-1:0] next_busy;
  lpr_cmd_e             cmd;
  logic                 fire;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st   = st;
    next_half = 1'b0;
    next_op   = op;
    next_ptr  = ptr;
    next_opb  = opb;
    next_owed = owed;
    next_err  = 1'b0;
    next_iref = 1'b0;
    next_refi = 10'h000;
    next_tmr  = (tmr != 3'h0) ? tmr - 3'h1 : 3'h0;
    next_ab_cnt = (ab_cnt != 3'h0) ? ab_cnt - 3'h1 : 3'h0;
    any_busy    = (next_ab_cnt != 3'h0);
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      next_pb_cnt[b] = (pb_cnt[b] != 2'h0) ? pb_cnt[b] - 2'h1 : 2'h0;
      any_busy       = any_busy || (next_pb_cnt[b] != 2'h0);
    end
    cmd  = LPR_DES;
    fire = 1'b0;
    // first edge cs high latches the opcode, second edge cs low completes it
    if (half && !link.cs)
    begin
      cmd  = lpr_decode(op);
      fire = 1'b1;
    end
    else if (half && link.cs)
    begin
      next_err = 1'b1;
    end
    else if (link.cs)
    begin
      next_half = 1'b1;
      next_op   = link.ca;
    end
    case (st)
      D_IDLE:
      begin
        if (fire && cmd == LPR_REFAB)
        begin
          next_ab_cnt = 3'(`LPR_RFCAB_CYC);
          next_owed   = 1'b0;
        end
        else if (fire && cmd == LPR_REFPB)
        begin
          next_pb_cnt[ptr] = 2'(`LPR_PB_WAIT_CYC);
          next_ptr         = ptr + 3'h1;
          next_opb         = opb + 3'h1;
          // eight per-bank refreshes counted from the exit, not from bank 0
          if (owed && opb == 3'h7)
          begin
            next_owed = 1'b0;
          end
        end
        else if (fire && cmd == LPR_SRE)
        begin
          // refused while an extra refresh is owed or a refresh still runs
          if (owed || any_busy)
          begin
            next_err = 1'b1;
          end
          else
          begin
            next_st  = D_SR;
            next_tmr = 3'(`LPR_SR_CYC);
          end
        end
        else if (fire && cmd == LPR_SRX)
        begin
          next_err = 1'b1;
        end
      end
      D_SR:
      begin
        // internal timer keeps the array refreshed with no external command
        next_refi = (refi == 10'(REFI_CYC - 1)) ? 10'h000 : refi + 10'h001;
        next_iref = (refi == 10'(REFI_CYC - 1));
        if (fire && !lpr_sr_legal(cmd, 1'b1))
        begin
          next_err = 1'b1;
        end
        else if (fire && cmd == LPR_SRX)
        begin
          // no abort at this density: full exit recovery every time
          next_err  = (tmr != 3'h0) || !link.cke;
          next_st   = D_XSR;
          next_tmr  = 3'(`LPR_XSR_CYC);
          next_owed = 1'b1;
          next_opb  = 3'h0;
        end
      end
      D_XSR:
      begin
        if (fire && !lpr_sr_legal(cmd, 1'b0))
        begin
          next_err = 1'b1;
        end
        if (tmr == 3'h0)
        begin
          next_st = D_IDLE;
        end
      end
      default: next_st = D_IDLE;
    endcase
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      next_busy[b] = (next_ab_cnt != 3'h0) || (next_pb_cnt[b] != 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // this channel's state is private: another channel is a separate instance
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st          <= D_IDLE;
      half        <= 1'b0;
      op          <= 6'h00;
      ab_cnt      <= 3'h0;
      ptr         <= 3'h0;
      opb         <= 3'h0;
      tmr         <= 3'h0;
      refi        <= 10'h000;
      owed        <= 1'b0;
      err         <= 1'b0;
      iref        <= 1'b0;
      sr_active_o <= 1'b0;
      pd_active_o <= 1'b0;
      int_ref_o   <= 1'b0;
      bank_busy_o <= '0;
      ref_owed_o  <= 1'b0;
      cmd_err_o   <= 1'b0;
      for (int b = 0; b < NUM_BANKS; b++)
      begin
        pb_cnt[b] <= 2'h0;
      end
    end
    else
    begin
      st          <= next_st;
      half        <= next_half;
      op          <= next_op;
      ab_cnt      <= next_ab_cnt;
      ptr         <= next_ptr;
      opb         <= next_opb;
      tmr         <= next_tmr;
      refi        <= next_refi;
      owed        <= next_owed;
      err         <= next_err;
      iref        <= next_iref;
      sr_active_o <= (next_st == D_SR);
      // power down is legal inside self refresh; the array keeps refreshing
      pd_active_o <= (next_st == D_SR) && !link.cke;
      int_ref_o   <= next_iref;
      bank_busy_o <= next_busy;
      ref_owed_o  <= next_owed;
      cmd_err_o   <= next_err;
      for (int b = 0; b < NUM_BANKS; b++)
      begin
        pb_cnt[b] <= next_pb_cnt[b];
      end
    end
  end

endmodule // lpr_dev
`default_nettype wire

//--- verilog/lpr_map.svh
// lpr_map.svh: timing counts, command opcodes and field positions of the
// refresh / self-refresh link. assumes a 20 MHz controller clock (50 ns).
`ifndef LPR_MAP_SVH
`define LPR_MAP_SVH

`define LPR_TCK_PS           50000
`define LPR_CYC_MIN(ps)      (((ps) + `LPR_TCK_PS - 1) / `LPR_TCK_PS)
`define LPR_MAX(a, b)        (((a) > (b)) ? (a) : (b))

`define LPR_NUM_BANKS        8
`define LPR_MAX_POSTPONE     8
`define LPR_T_REFW_NS        32000000
`define LPR_REFS_PER_WINDOW  8192
// average interval is a longest time: rounded down
`define LPR_REFI_CYC         (`LPR_T_REFW_NS / `LPR_REFS_PER_WINDOW * 1000 / `LPR_TCK_PS)

`define LPR_T_RFCAB_PS       180000
`define LPR_T_RFCPB_PS       90000
`define LPR_T_PBR2PBR_PS     90000
`define LPR_T_XSR_ADD_PS     7500
`define LPR_T_SR_PS          15000
`define LPR_T_ESCKE_PS       1750
`define LPR_XSR_TCK          2
`define LPR_SR_TCK           3
`define LPR_ESCKE_TCK        3

`define LPR_RFCAB_CYC        `LPR_CYC_MIN(`LPR_T_RFCAB_PS)
`define LPR_PB_WAIT_CYC      `LPR_MAX(`LPR_CYC_MIN(`LPR_T_RFCPB_PS), `LPR_CYC_MIN(`LPR_T_PBR2PBR_PS))
`define LPR_XSR_CYC          `LPR_MAX(`LPR_CYC_MIN(`LPR_T_RFCAB_PS + `LPR_T_XSR_ADD_PS), `LPR_XSR_TCK)
`define LPR_SR_CYC           `LPR_MAX(`LPR_CYC_MIN(`LPR_T_SR_PS), `LPR_SR_TCK)
`define LPR_ESCKE_CYC        `LPR_MAX(`LPR_CYC_MIN(`LPR_T_ESCKE_PS), `LPR_ESCKE_TCK)

// first-edge opcodes on ca[4:0] with cs high; ca[5] selects all-bank refresh
`define LPR_CA_AB_BIT        5
`define LPR_OP_SRE           5'h18
`define LPR_OP_REF           5'h08
`define LPR_OP_SRX           5'h14
`define LPR_OP_MRW1          5'h06
`define LPR_OP_MRW2          5'h16
`define LPR_OP_MRR1          5'h0E
`define LPR_OP_MPC           5'h00
`define LPR_OP_CAS2          5'h12
`define LPR_RATE_RESET       3'h3

`endif

//--- verilog/lpr_pkg.sv
// lpr_pkg: command, state types and decode helpers shared by both ends.
// assumes lpr_map.svh is on the include path.
`default_nettype none
`include "lpr_map.svh"
package lpr_pkg;

  typedef enum logic [3:0] {
    LPR_DES, LPR_REFAB, LPR_REFPB, LPR_SRE, LPR_SRX,
    LPR_MRR1, LPR_MRW1, LPR_MRW2, LPR_MPC, LPR_CAS2, LPR_OTHER
  } lpr_cmd_e;

  typedef enum logic [2:0] {C_IDLE, C_REF2, C_SRE2, C_SR, C_SRX2} lpr_ctl_st_e;
  typedef enum logic [1:0] {D_IDLE, D_SR, D_XSR} lpr_dev_st_e;

  function automatic lpr_cmd_e lpr_decode(input logic [5:0] ca);
    case (ca[4:0])
      `LPR_OP_SRE:  lpr_decode = LPR_SRE;
      `LPR_OP_REF:  lpr_decode = ca[`LPR_CA_AB_BIT] ? LPR_REFAB : LPR_REFPB;
      `LPR_OP_SRX:  lpr_decode = LPR_SRX;
      `LPR_OP_MRW1: lpr_decode = LPR_MRW1;
      `LPR_OP_MRW2: lpr_decode = LPR_MRW2;
      `LPR_OP_MRR1: lpr_decode = LPR_MRR1;
      `LPR_OP_MPC:  lpr_decode = LPR_MPC;
      `LPR_OP_CAS2: lpr_decode = LPR_CAS2;
      default:      lpr_decode = LPR_OTHER;
    endcase
  endfunction

  // commands legal in self refresh and during exit recovery (srx only in sr)
  function automatic logic lpr_sr_legal(input lpr_cmd_e c, input logic in_sr);
    case (c)
      LPR_MRR1, LPR_CAS2, LPR_DES, LPR_MPC, LPR_MRW1, LPR_MRW2: lpr_sr_legal = 1'b1;
      LPR_SRX: lpr_sr_legal = in_sr;
      default: lpr_sr_legal = 1'b0;
    endcase
  endfunction

  // average refresh interval scaled by the temperature-derived rate
  function automatic logic [9:0] lpr_refi_limit(input logic [2:0] rate, input int base);
    case (rate)
      3'h0, 3'h1: lpr_refi_limit = 10'(base * 4);
      3'h2:       lpr_refi_limit = 10'(base * 2);
      3'h4:       lpr_refi_limit = 10'(base / 2);
      3'h5, 3'h6, 3'h7: lpr_refi_limit = 10'(base / 4);
      default:    lpr_refi_limit = 10'(base);
    endcase
  endfunction

endpackage
`default_nettype wire

//--- verilog/lpr_if.sv
// lpr_if: command/address link of one channel between controller and sdram.
// assumes both ends run on the same clock; no reset is carried on the link.
`timescale 1ns/1ps
`default_nettype none
interface lpr_if;
  logic       cs;
  logic [5:0] ca;
  logic       cke;

  modport ctl (output cs, output ca, output cke);
  modport dev (input cs, input ca, input cke);
endinterface
`default_nettype wire

//--- verilog/lpr_ctl.sv
// lpr_ctl: controller end of one channel; schedules refreshes, enters and
// leaves self refresh with its residency and recovery, power down inside it.
// assumes the sdram end samples lpr_if on the same clock, which never stops.
`timescale 1ns/1ps
`default_nettype none
`include "lpr_map.svh"
module lpr_ctl
  import lpr_pkg::*;
#(
  parameter int REFI_CYC  = `LPR_REFI_CYC,
  parameter int MAX_POST  = `LPR_MAX_POSTPONE,
  parameter int NUM_BANKS = `LPR_NUM_BANKS
)(
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  lpr_if.ctl              link,
  input  wire logic       sr_req_i,
  input  wire logic       pd_req_i,
  input  wire logic       busy_i,
  input  wire logic       pb_mode_i,
  input  wire logic [2:0] mr4_rate_i,
  input  wire logic       mr4_valid_i,
  output logic            sr_active_o,
  output logic            ready_o,
  output logic            ref_owed_o,
  output logic [3:0]      postponed_o
);

  ////////////////////////////////////////////////////////////////////////////
  lpr_ctl_st_e st, next_st;
  logic [2:0]  cnt, next_cnt;
  logic [1:0]  age, next_age;
  logic [9:0]  refi, next_refi;
  logic [9:0]  limit;
  logic [3:0]  pend, next_pend;
  logic        owed, next_owed;
  logic [2:0]  ptr, next_ptr;
  logic [2:0]  opb, next_opb;
  logic [2:0]  rate, next_rate;
  logic        pb, next_pb;
  logic        next_cs;
  logic [5:0]  next_ca;
  logic        next_cke;
  logic        tick;
  logic        need_ref;

  ////////////////////////////////////////////////////////////////////////////
  // refresh interval bookkeeping
  always_comb
  begin
    // a rate read back from the device replaces the table rate
    next_rate = mr4_valid_i ? mr4_rate_i : rate;
    // 32 ms over 8192 commands at rate 3, scaled for other rates, counted in whole cycles
    limit     = lpr_refi_limit(rate, REFI_CYC);
    tick      = 1'b0;
    next_refi = refi;
    // the postponed count is frozen while the device refreshes itself
    if (st != C_SR)
    begin
      tick      = (refi >= limit - 10'h001);
      next_refi = tick ? 10'h000 : refi + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_comb
  begin
    next_st   = st;
    next_cs   = 1'b0;
    next_ca   = 6'h00;
    next_cke  = link.cke;
    next_cnt  = (cnt != 3'h0) ? cnt - 3'h1 : 3'h0;
    next_age  = age;
    next_owed = owed;
    next_ptr  = ptr;
    next_opb  = opb;
    next_pb   = pb;
    next_pend = (tick && pend != 4'hF) ? pend + 4'h1 : pend;
    // refresh now if owed, if idle time allows, or if postponing hit its cap
    need_ref  = owed || (pend != 4'h0 && (!busy_i || pend >= 4'(MAX_POST)));
    case (st)
      C_IDLE:
      begin
        // cnt holds off every command through trfc and txsr
        if (cnt == 3'h0)
        begin
          if (need_ref)
          begin
            next_cs = 1'b1;
            next_ca = {!pb_mode_i, `LPR_OP_REF};
            next_pb = pb_mode_i;
            next_st = C_REF2;
          end
          else if (sr_req_i && !busy_i)
          begin
            next_cs = 1'b1;
            next_ca = {1'b0, `LPR_OP_SRE};
            next_st = C_SRE2;
          end
        end
      end
      C_REF2:
      begin
        next_st = C_IDLE;
        if (pb)
        begin
          // bank pointer walks all eight banks; eight of these make one unit
          next_cnt = 3'(`LPR_PB_WAIT_CYC);
          next_ptr = ptr + 3'h1;
          next_opb = opb + 3'h1;
        end
        else
        begin
          next_cnt = 3'(`LPR_RFCAB_CYC);
        end
        // the extra refresh comes on top of the regular ones; per-bank it
        // takes eight counted from the exit, wherever the pointer stood
        if (owed)
        begin
          if (!pb || opb == 3'h7)
          begin
            next_owed = 1'b0;
          end
        end
        else if ((!pb || ptr == 3'(NUM_BANKS - 1)) && next_pend != 4'h0)
        begin
          next_pend = next_pend - 4'h1;
        end
      end
      C_SRE2:
      begin
        // second edge: cs low, ca don't care
        next_age = 2'h0;
        next_st  = C_SR;
      end
      C_SR:
      begin
        // only deselects and the exit's first edge go out here; the clock is never gated
        next_age = (age != 2'h3) ? age + 2'h1 : age;
        if (pd_req_i && age >= 2'(`LPR_ESCKE_CYC - 1))
        begin
          next_cke = 1'b0;
        end
        else if (!pd_req_i)
        begin
          next_cke = 1'b1;
        end
        if (!sr_req_i && !pd_req_i && link.cke && age >= 2'(`LPR_SR_CYC - 1))
        begin
          next_cs = 1'b1;
          next_ca = {1'b0, `LPR_OP_SRX};
          next_st = C_SRX2;
        end
      end
      C_SRX2:
      begin
        // full recovery, no abort shortcut; only deselects until it ends
        next_cnt  = 3'(`LPR_XSR_CYC);
        next_owed = 1'b1;
        next_opb  = 3'h0;
        next_st   = C_IDLE;
      end
      default: next_st = C_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // one instance per channel; nothing here is shared with another channel
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st          <= C_IDLE;
      cnt         <= 3'h0;
      age         <= 2'h0;
      refi        <= 10'h000;
      pend        <= 4'h0;
      owed        <= 1'b0;
      ptr         <= 3'h0;
      opb         <= 3'h0;
      pb          <= 1'b0;
      rate        <= `LPR_RATE_RESET;
      link.cs     <= 1'b0;
      link.ca     <= 6'h00;
      link.cke    <= 1'b1;
      sr_active_o <= 1'b0;
      ready_o     <= 1'b0;
      ref_owed_o  <= 1'b0;
      postponed_o <= 4'h0;
    end
    else
    begin
      st          <= next_st;
      cnt         <= next_cnt;
      age         <= next_age;
      refi        <= next_refi;
      pend        <= next_pend;
      owed        <= next_owed;
      ptr         <= next_ptr;
      opb         <= next_opb;
      pb          <= next_pb;
      rate        <= next_rate;
      link.cs     <= next_cs;
      link.ca     <= next_ca;
      link.cke    <= next_cke;
      sr_active_o <= (next_st == C_SR);
      ready_o     <= (next_st == C_IDLE) && (next_cnt == 3'h0);
      ref_owed_o  <= next_owed;
      postponed_o <= next_pend;
    end
  end

endmodule // lpr_ctl
`default_nettype wire

//--- testbench/lpr_link_properties.sv
// lpr_link_properties: protocol checks on the controller-driven link.
// assumes one clock domain; cs, ca and cke come straight from lpr_if.
`timescale 1ns/1ps
`default_nettype none
`include "lpr_map.svh"
module lpr_link_properties (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic       cs,
  input  wire logic [5:0] ca,
  input  wire logic       cke
);
  logic       in_sr;
  logic       owed;
  logic [2:0] pb_cnt;
  wire logic  sre   = cs && ca[4:0] == `LPR_OP_SRE;
  wire logic  srx   = cs && ca[4:0] == `LPR_OP_SRX;
  wire logic  refab = cs && ca[4:0] == `LPR_OP_REF && ca[5];
  wire logic  refpb = cs && ca[4:0] == `LPR_OP_REF && !ca[5];

  ////////////////////////////////////////////////////////////////////////////
  // owed stays up until a whole unit: one all-bank or eight per-bank
  always_ff @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      in_sr  <= 1'b0;
      owed   <= 1'b0;
      pb_cnt <= 3'h0;
    end
    else
    begin
      if (sre)
        in_sr <= 1'b1;
      if (srx)
        in_sr <= 1'b0;
      if (srx)
        owed <= 1'b1;
      else if (refab || (refpb && owed && pb_cnt == 3'h7))
        owed <= 1'b0;
      if (srx)
        pb_cnt <= 3'h0;
      else if (refpb && owed)
        pb_cnt <= pb_cnt + 3'h1;
    end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  chk_two_edge_cmd: assert property (cs |=> !cs)
    else $error("command first edge not followed by a second edge");
  chk_sr_residency: assert property (sre |=> !srx [*3])
    else $error("self refresh left before the minimum residency");
  chk_cke_hold: assert property (sre |=> cke [*3])
    else $error("cke dropped too soon after self refresh entry");
  chk_refab_wait: assert property (refab |=> !cs [*4])
    else $error("command issued inside all-bank refresh cycle time");
  chk_xsr_wait: assert property (srx |=> !cs [*3])
    else $error("command issued inside exit recovery");
  chk_extra_ref: assert property (sre |-> !owed)
    else $error("self refresh entered without the extra refresh");
  chk_sr_cmds: assert property (in_sr && cs |-> ca[4:0] inside {`LPR_OP_SRX, `LPR_OP_MRR1,
      `LPR_OP_CAS2, `LPR_OP_MPC, `LPR_OP_MRW1, `LPR_OP_MRW2})
    else $error("illegal command during self refresh");
  chk_cke_in_sr: assert property (!cke |-> in_sr)
    else $error("cke low outside self refresh");
  chk_srx_state: assert property (srx |-> in_sr && cke && $past(cke))
    else $error("self refresh exit outside self refresh or in power down");
endmodule // lpr_link_properties
`default_nettype wire

//--- testbench/tb_lpddr4_refresh_self_refresh.sv
// tb_lpddr4_refresh_self_refresh: controller and sdram ends face each other;
// a second sdram end is driven by hand with misuse. assumes lpr_map.svh.
`timescale 1ns/1ps
`default_nettype none
`include "lpr_map.svh"
module tb_lpddr4_refresh_self_refresh;
  import lpr_pkg::*;
  logic       mclk_i, rstn_i, sr_req, pd_req, busy, pb_mode, mr4_valid, e_cs;
  logic [2:0] mr4_rate;
  logic [5:0] e_ca;
  logic       c_sr, c_rdy, c_owed, d_sr, d_pd, d_int, d_owed, d_err, e_sr, e_err;
  logic [3:0] c_post;
  logic [7:0] d_bank, banks_seen;
  int         num_errors, check_count, n_ab, n_pb, n_int, n_bad;

  lpr_if link_bus();
  lpr_if err_bus();
  assign err_bus.cs  = e_cs;
  assign err_bus.ca  = e_ca;
  assign err_bus.cke = 1'b1;

  // interval shortened to 8 cycles to keep the run short
  lpr_ctl #(.REFI_CYC(8)) lpr_ctl_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .link(link_bus),
    .sr_req_i(sr_req), .pd_req_i(pd_req), .busy_i(busy), .pb_mode_i(pb_mode),
    .mr4_rate_i(mr4_rate), .mr4_valid_i(mr4_valid), .sr_active_o(c_sr), .ready_o(c_rdy),
    .ref_owed_o(c_owed), .postponed_o(c_post));
  lpr_dev #(.REFI_CYC(8)) lpr_dev_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .link(link_bus),
    .sr_active_o(d_sr), .pd_active_o(d_pd), .int_ref_o(d_int), .bank_busy_o(d_bank),
    .ref_owed_o(d_owed), .cmd_err_o(d_err));
  lpr_dev #(.REFI_CYC(8)) lpr_dev_err_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .link(err_bus),
    .sr_active_o(e_sr), .pd_active_o(), .int_ref_o(), .bank_busy_o(), .ref_owed_o(),
    .cmd_err_o(e_err));
  lpr_link_properties lpr_link_properties_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .cs(link_bus.cs), .ca(link_bus.ca), .cke(link_bus.cke));

  always #25 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i)
  begin
    if (link_bus.cs === 1'b1 && link_bus.ca[4:0] === `LPR_OP_REF)
      if (link_bus.ca[5]) n_ab++; else n_pb++;
    if (d_int === 1'b1) n_int++;
    if (e_err === 1'b1) n_bad++;
    banks_seen |= d_bank;
    if (rstn_i && d_err !== 1'b0)
    begin
      num_errors++;
      $display("ERROR %0t sdram end flagged the controller", $time);
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic wait_on(ref logic s, input logic v);
    for (int i = 0; i < 100 && s !== v; i++)
      cyc(1);
  endtask

  task automatic send(input logic [5:0] ca);
    e_cs = 1'b1;
    e_ca = ca;
    cyc(1);
    e_cs = 1'b0;
    cyc(3);
  endtask

  task automatic t_rate(input logic [2:0] rate, input int lo, input int hi);
    mr4_rate = rate;
    mr4_valid = 1'b1;
    cyc(1);
    mr4_valid = 1'b0;
    cyc(40);
    n_ab = 0;
    cyc(160);
    chk(n_ab >= lo && n_ab <= hi, "refresh count off for rate");
  endtask

  task automatic t_per_bank;
    pb_mode = 1'b1;
    banks_seen = 8'h00;
    n_ab = 0;
    n_pb = 0;
    cyc(120);
    chk(banks_seen === 8'hFF && n_ab == 0 && n_pb >= 8, "per-bank sweep");
    pb_mode = 1'b0;
    // the shortened interval outruns per-bank refresh; let all-bank repay it
    for (int i = 0; i < 400 && c_post !== 4'h0; i++)
      cyc(1);
    chk(c_post === 4'h0, "per-bank backlog not repaid");
  endtask

  task automatic t_postpone;
    busy = 1'b1;
    sr_req = 1'b1;
    n_ab = 0;
    cyc(120);
    chk(c_post <= 4'h8 && c_post >= 4'h7 && n_ab >= 6 && n_ab <= 8, "postpone limit");
    chk(c_sr === 1'b0, "self refresh entered while busy");
    busy = 1'b0;
    sr_req = 1'b0;
    for (int i = 0; i < 300 && c_post !== 4'h0; i++)
      cyc(1);
    chk(c_post === 4'h0, "postponed not repaid");
    wait_on(c_rdy, 1'b1);
    chk(c_rdy === 1'b1, "not ready after repay");
  endtask

  task automatic t_self_refresh;
    logic [3:0] post;
    sr_req = 1'b1;
    wait_on(d_sr, 1'b1);
    chk(c_sr === 1'b1 && d_sr === 1'b1, "self refresh not entered");
    post = c_post;
    n_ab = 0;
    n_pb = 0;
    n_int = 0;
    cyc(40);
    chk(n_int >= 4 && n_int <= 5 && n_ab + n_pb == 0, "internal refresh");
    chk(c_post === post, "postponed count moved in self refresh");
    pd_req = 1'b1;
    wait_on(d_pd, 1'b1);
    chk(link_bus.cke === 1'b0 && d_sr === 1'b1, "power down in self refresh");
    pd_req = 1'b0;
    wait_on(d_pd, 1'b0);
    sr_req = 1'b0;
    wait_on(d_sr, 1'b0);
    cyc(1);
    chk(c_owed === 1'b1 && d_owed === 1'b1 && c_sr === 1'b0, "extra refresh owed");
    sr_req = 1'b1;
    wait_on(d_sr, 1'b1);
    chk(n_ab >= 1 && d_owed === 1'b0 && c_owed === 1'b0, "re-entry before repay");
    sr_req = 1'b0;
    wait_on(c_rdy, 1'b1);
    cyc(20);
  endtask

  task automatic t_misuse;
    e_cs = 1'b1;
    e_ca = {1'b1, `LPR_OP_REF};
    cyc(2);
    e_cs = 1'b0;
    cyc(3);
    chk(n_bad == 1, "two first edges accepted");
    send({1'b0, `LPR_OP_SRX});
    chk(n_bad == 2 && e_sr === 1'b0, "exit accepted outside self refresh");
    send({1'b0, `LPR_OP_SRE});
    send({1'b1, `LPR_OP_REF});
    chk(n_bad == 3 && e_sr === 1'b1, "refresh accepted in self refresh");
    send({1'b0, `LPR_OP_MRR1});
    chk(n_bad == 3, "legal command refused in self refresh");
    send({1'b0, `LPR_OP_SRX});
    cyc(6);
    send({1'b0, `LPR_OP_SRE});
    chk(n_bad == 4 && e_sr === 1'b0, "entry accepted while refresh owed");
  endtask

  task stop_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(50 * 5000);
    num_errors++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test;
  end

  initial
  begin
    mclk_i = 1'b0;
    rstn_i = 1'b0;
    {sr_req, pd_req, busy, pb_mode, mr4_valid, e_cs} = 6'h00;
    mr4_rate = 3'h3;
    e_ca = 6'h00;
    banks_seen = 8'h00;
    repeat (2) @(posedge mclk_i);
    #1;
    rstn_i = 1'b1;
    cyc(2);
    chk(c_rdy === 1'b1 && link_bus.cke === 1'b1 && d_sr === 1'b0, "idle after reset");
    t_rate(3'h3, 19, 21);
    t_rate(3'h2, 9, 11);
    t_rate(3'h0, 4, 6);
    t_rate(3'h3, 19, 21);
    t_per_bank;
    t_postpone;
    t_self_refresh;
    t_misuse;
    stop_test;
  end
endmodule // tb_lpddr4_refresh_self_refresh
`default_nettype wire
